/* File: include/lgb_pkg.sv */
// Constants and carrier types of the link pin back-channel block
package lgb_pkg;
  // Register offsets
  localparam logic [7:0] LGB_OFS_PIN9_CFG  = 8'h1a;
  localparam logic [7:0] LGB_OFS_LINK0_CFG = 8'h1d;
  localparam logic [7:0] LGB_OFS_LINK12_CFG = 8'h1e;
  localparam logic [7:0] LGB_OFS_LINK3_CFG = 8'h1f;
  localparam logic [7:0] LGB_OFS_LOC56_CFG = 8'h20;
  localparam logic [7:0] LGB_OFS_LOC78_CFG = 8'h21;
  localparam logic [7:0] LGB_OFS_RATE      = 8'h23;
  localparam logic [7:0] LGB_OFS_PORT_SEL  = 8'h34;
  localparam logic [7:0] LGB_OFS_FAST_CTL  = 8'h43;
  localparam logic [7:0] LGB_OFS_STAT_LO   = 8'h6e;
  localparam logic [7:0] LGB_OFS_STAT_HI   = 8'h6f;
  // Field positions
  localparam int LGB_RATE_DIV_BIT   = 6;
  localparam int LGB_RATE_HS_BIT    = 4;
  localparam int LGB_PSEL_P0_BIT    = 0;
  localparam int LGB_PSEL_P1_BIT    = 1;
  localparam int LGB_STAT_LOC_LSB   = 5;
  localparam int LGB_STAT_PIN9_BIT  = 1;
  localparam int LGB_STAT_PIN8_BIT  = 0;
  // Pin nibble codes
  localparam logic [3:0] LGB_CFG_FWD    = 4'h5;
  localparam logic [3:0] LGB_CFG_BC_IN  = 4'h3;
  localparam logic [3:0] LGB_CFG_OUT_LO = 4'h1;
  localparam logic [3:0] LGB_CFG_OUT_HI = 4'h9;
  // Fast channel modes and samples per frame
  localparam logic [2:0] LGB_FAST_NORMAL = 3'h0;
  localparam logic [2:0] LGB_FAST_FOUR   = 3'h3;
  localparam logic [2:0] LGB_FAST_TWO    = 3'h2;
  localparam logic [2:0] LGB_FAST_ONE    = 3'h1;
  localparam logic [3:0] LGB_SPF_NORMAL  = 4'h1;
  localparam logic [3:0] LGB_SPF_FOUR    = 4'h6;
  localparam logic [3:0] LGB_SPF_TWO     = 4'ha;
  localparam logic [3:0] LGB_SPF_ONE     = 4'hf;
  // Oscillator divider terminal counts: divide by 4, 2, 1
  localparam logic [1:0] LGB_DIV_SLOW = 2'h3;
  localparam logic [1:0] LGB_DIV_MID  = 2'h1;
  localparam logic [1:0] LGB_DIV_FAST = 2'h0;
  // Reset values
  localparam logic [1:0] LGB_RST_PSEL = 2'h1;
  localparam logic [3:0] LGB_RST_CFG  = 4'h0;
  localparam logic [2:0] LGB_RST_FAST = 3'h0;
  localparam logic       LGB_RST_DIV  = 1'b0;
  // Back-channel buffer
  localparam int LGB_FIFO_DEPTH = 16;

  typedef struct packed {
    logic fwd_out;
    logic bc_in;
    logic local_drive;
    logic local_level;
  } lgb_pin_mode_t;

  typedef struct packed {
    logic       port;
    logic       frame_start;
    logic [3:0] pins;
  } lgb_bc_word_t;

  typedef enum logic [1:0] {
    LGB_SMP_WAIT  = 2'b01,
    LGB_SMP_PORT1 = 2'b10
  } lgb_smp_state_t;
endpackage

/* File: rtl/lgb_link_gpio.sv */
// Link pin control, local register pins and back-channel sampler with its buffer
// Contract
// - Link pins: forward output or back-channel input
// - Port-select field routes shared config accesses
// - Both selected: read port1, write both
// - Secondary pins operate only in two-lane
// - Code 0x5 forward, 0x3 back-channel input
// - Adopt 18-bit colour sent by serializer
// - Pin levels readable; local output mode allowed
// - Divider bit: oscillator divide 4 or 2
// - High-speed bit forces divide by one; strap
// - Fast mode field sets pins, samples per frame
// - Fast modes drop identity, capability, lock signalling
// - Pins 5-8 are register-only pins
// - Register pin overrides shared audio input
// - Local pin state stays local
// - Local nibble: 0x1 low, 0x9 high, 0x3 input
// - Input levels reported in read-only status
`timescale 1ns/1ps
`default_nettype none

module lgb_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  wire              push;
  wire              pop;

  assign in_ready  = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
  assign out_valid = (wr_ptr_r != rd_ptr_r);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

module lgb_link_gpio (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Register access
  input  wire logic                reg_wr_en,
  input  wire logic                reg_rd_en,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  output logic                     reg_rd_valid,
  // Link state
  input  wire logic                two_lane_mode,
  input  wire logic                power_down_input,
  input  wire logic                strap_config_input,
  // Forward channel from the serializer
  input  wire logic                fwd_valid,
  input  wire logic [1:0][3:0]     fwd_value,
  input  wire logic                fwd_color_18bit,
  output logic                     color_18bit_mode,
  // Link pins, index 0 primary port, 1 secondary port
  input  wire logic [1:0][3:0]     link_pin_in,
  output logic [1:0][3:0]          link_pin_out,
  output logic [1:0][3:0]          link_pin_oe,
  // Local register pins, index 0..3 pins 5..8, index 4 pin 9
  input  wire logic [4:0]          local_pin_in,
  output logic [4:0]               local_pin_out,
  output logic [4:0]               local_pin_oe,
  // Audio inputs sharing pads with pins 5..8
  output logic [3:0]               audio_data_out,
  // Back channel
  output logic                     bc_word_valid,
  input  wire logic                bc_word_ready,
  output lgb_pkg::lgb_bc_word_t    bc_word,
  output logic                     bc_status_enable,
  output logic                     bc_bit_tick
);
  import lgb_pkg::*;

  function automatic lgb_pin_mode_t pin_mode(input logic [3:0] nib);
    lgb_pin_mode_t m;
    m.fwd_out     = (nib == LGB_CFG_FWD);
    m.bc_in       = (nib == LGB_CFG_BC_IN);
    m.local_drive = (nib == LGB_CFG_OUT_LO) || (nib == LGB_CFG_OUT_HI);
    m.local_level = (nib == LGB_CFG_OUT_HI);
    return m;
  endfunction

  // Control registers
  logic [1:0][3:0][3:0] cfg_r;
  logic [4:0][3:0]      loc_r;
  logic                 rate_div_r;
  logic                 rate_hs_r;
  logic [1:0]           psel_r;
  logic [2:0]           fast_r;
  logic                 boot_r;
  logic [1:0][3:0]      fwd_hold_r;
  logic [7:0]           rdata_r;
  logic                 rd_valid_r;

  // Write decode
  wire wr_pin9   = reg_wr_en && (reg_addr == LGB_OFS_PIN9_CFG);
  wire wr_link0  = reg_wr_en && (reg_addr == LGB_OFS_LINK0_CFG);
  wire wr_link12 = reg_wr_en && (reg_addr == LGB_OFS_LINK12_CFG);
  wire wr_link3  = reg_wr_en && (reg_addr == LGB_OFS_LINK3_CFG);
  wire wr_loc56  = reg_wr_en && (reg_addr == LGB_OFS_LOC56_CFG);
  wire wr_loc78  = reg_wr_en && (reg_addr == LGB_OFS_LOC78_CFG);
  wire wr_rate   = reg_wr_en && (reg_addr == LGB_OFS_RATE);
  wire wr_psel   = reg_wr_en && (reg_addr == LGB_OFS_PORT_SEL);
  wire wr_fast   = reg_wr_en && (reg_addr == LGB_OFS_FAST_CTL);

  // Shared link registers read from port 1 whenever its select bit is set
  wire          rd_port = psel_r[LGB_PSEL_P1_BIT];
  wire [3:0][3:0] rd_cfg = cfg_r[rd_port];

  // Port-select, rate and fast channel registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      psel_r     <= LGB_RST_PSEL;
      rate_div_r <= LGB_RST_DIV;
      rate_hs_r  <= 1'b0;
      fast_r     <= LGB_RST_FAST;
      boot_r     <= 1'b1;
    end else begin
      boot_r <= 1'b0;
      if (wr_psel) psel_r <= reg_wdata[1:0];
      if (wr_fast) fast_r <= reg_wdata[2:0];
      if (wr_rate) begin
        rate_div_r <= reg_wdata[LGB_RATE_DIV_BIT];
        rate_hs_r  <= reg_wdata[LGB_RATE_HS_BIT];
      end else if (boot_r) begin
        rate_hs_r <= strap_config_input;
      end
    end
  end

  // Link pin configuration, one copy per port
  genvar p;
  genvar i;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          cfg_r[p] <= {4{LGB_RST_CFG}};
        end else if (psel_r[p]) begin
          if (wr_link0) cfg_r[p][0] <= reg_wdata[3:0];
          if (wr_link12) begin
            cfg_r[p][1] <= reg_wdata[3:0];
            cfg_r[p][2] <= reg_wdata[7:4];
          end
          if (wr_link3) cfg_r[p][3] <= reg_wdata[3:0];
        end
      end

      // Secondary port pins stay idle outside two-lane operation
      wire port_on = !power_down_input && ((p == 0) || two_lane_mode);

      for (i = 0; i < 4; i++) begin : g_pin
        lgb_pin_mode_t m;
        logic          out_r;
        logic          oe_r;
        assign m = pin_mode(cfg_r[p][i]);
        always_ff @(posedge clk or negedge reset_n) begin
          if (!reset_n) begin
            out_r <= 1'b0;
            oe_r  <= 1'b0;
          end else begin
            oe_r  <= port_on && (m.fwd_out || m.local_drive);
            out_r <= m.fwd_out ? fwd_hold_r[p][i] : m.local_level;
          end
        end
        assign link_pin_out[p][i] = out_r;
        assign link_pin_oe[p][i]  = oe_r;
      end
    end
  endgenerate

  // Forward-channel values and colour depth loaded from the serializer
  logic color_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fwd_hold_r <= '0;
      color_r    <= 1'b0;
    end else if (fwd_valid) begin
      fwd_hold_r <= fwd_value;
      color_r    <= fwd_color_18bit;
    end
  end
  assign color_18bit_mode = color_r;

  // Local register pins; nothing here reaches the link
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      loc_r <= {5{LGB_RST_CFG}};
    end else begin
      if (wr_loc56) begin
        loc_r[0] <= reg_wdata[3:0];
        loc_r[1] <= reg_wdata[7:4];
      end
      if (wr_loc78) begin
        loc_r[2] <= reg_wdata[3:0];
        loc_r[3] <= reg_wdata[7:4];
      end
      if (wr_pin9) loc_r[4] <= reg_wdata[3:0];
    end
  end

  generate
    for (i = 0; i < 5; i++) begin : g_local
      lgb_pin_mode_t lm;
      logic          lout_r;
      logic          loe_r;
      assign lm = pin_mode(loc_r[i]);
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          lout_r <= 1'b0;
          loe_r  <= 1'b0;
        end else begin
          loe_r  <= !power_down_input && lm.local_drive;
          lout_r <= lm.local_level;
        end
      end
      assign local_pin_out[i] = lout_r;
      assign local_pin_oe[i]  = loe_r;
      if (i < 4) begin : g_audio
        // An enabled register pin takes the pad away from the audio input
        wire taken = lm.local_drive || lm.bc_in;
        assign audio_data_out[i] = taken ? 1'b0 : local_pin_in[i];
      end
    end
  endgenerate

  // Read path
  wire [7:0] stat_lo = {local_pin_in[2:0], 1'b0, link_pin_in[rd_port]};
  wire [7:0] stat_hi = {6'h00, local_pin_in[4], local_pin_in[3]};
  wire [7:0] rate_rd = {1'b0, rate_div_r, 1'b0, rate_hs_r, 4'h0};
  wire [7:0] rd_mux =
    (reg_addr == LGB_OFS_PIN9_CFG)   ? {4'h0, loc_r[4]} :
    (reg_addr == LGB_OFS_LINK0_CFG)  ? {4'h0, rd_cfg[0]} :
    (reg_addr == LGB_OFS_LINK12_CFG) ? {rd_cfg[2], rd_cfg[1]} :
    (reg_addr == LGB_OFS_LINK3_CFG)  ? {4'h0, rd_cfg[3]} :
    (reg_addr == LGB_OFS_LOC56_CFG)  ? {loc_r[1], loc_r[0]} :
    (reg_addr == LGB_OFS_LOC78_CFG)  ? {loc_r[3], loc_r[2]} :
    (reg_addr == LGB_OFS_RATE)       ? rate_rd :
    (reg_addr == LGB_OFS_PORT_SEL)   ? {6'h00, psel_r} :
    (reg_addr == LGB_OFS_FAST_CTL)   ? {5'h00, fast_r} :
    (reg_addr == LGB_OFS_STAT_LO)    ? stat_lo :
    (reg_addr == LGB_OFS_STAT_HI)    ? stat_hi : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r    <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en) rdata_r <= rd_mux;
    end
  end
  assign reg_rdata    = rdata_r;
  assign reg_rd_valid = rd_valid_r;

  // Back-channel rate divider on the oscillator (the block clock)
  logic [1:0]     div_cnt_r;
  lgb_smp_state_t state_r;
  logic [3:0]     spf_cnt_r;
  logic           fs_r;
  logic [3:0]     p1_sample_r;
  logic           fifo_in_ready;

  wire [1:0] div_term = rate_hs_r ? LGB_DIV_FAST : (rate_div_r ? LGB_DIV_MID : LGB_DIV_SLOW);
  wire       stall    = (state_r != LGB_SMP_WAIT) || !fifo_in_ready || power_down_input;
  wire       tick     = !stall && (div_cnt_r == div_term);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_r <= 2'h0;
    end else if (!stall) begin
      div_cnt_r <= tick ? 2'h0 : div_cnt_r + 2'h1;
    end
  end
  assign bc_bit_tick = tick;

  // Fast mode picks the pins carried and the samples per frame
  wire       mode_normal = (fast_r == LGB_FAST_NORMAL);
  wire       mode_four   = (fast_r == LGB_FAST_FOUR);
  wire       mode_two    = (fast_r == LGB_FAST_TWO);
  wire       mode_one    = (fast_r == LGB_FAST_ONE);
  wire       gpio_mode   = mode_normal || mode_four || mode_two || mode_one;
  wire [3:0] pin_mask    = mode_two ? 4'h3 : (mode_one ? 4'h1 : 4'hf);
  wire [3:0] spf         = mode_four ? LGB_SPF_FOUR :
                           mode_two ? LGB_SPF_TWO :
                           mode_one ? LGB_SPF_ONE : LGB_SPF_NORMAL;

  // Identity, capability and lock signalling only in normal mode
  assign bc_status_enable = mode_normal;

  // Per-port sample of the pins set as back-channel inputs
  logic [1:0][3:0] bc_sample;
  generate
    for (p = 0; p < 2; p++) begin : g_smp
      for (i = 0; i < 4; i++) begin : g_bit
        lgb_pin_mode_t sm;
        assign sm = pin_mode(cfg_r[p][i]);
        assign bc_sample[p][i] = sm.bc_in && pin_mask[i] && link_pin_in[p][i];
      end
    end
  endgenerate

  wire push0 = tick && gpio_mode;
  wire push1 = (state_r == LGB_SMP_PORT1) && fifo_in_ready;
  wire frame_start = (spf_cnt_r == 4'h0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spf_cnt_r <= 4'h0;
    end else if (wr_fast) begin
      spf_cnt_r <= 4'h0;
    end else if (push0) begin
      spf_cnt_r <= (spf_cnt_r == spf - 4'h1) ? 4'h0 : spf_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fs_r        <= 1'b0;
      p1_sample_r <= 4'h0;
    end else if (push0) begin
      fs_r        <= frame_start;
      p1_sample_r <= bc_sample[1];
    end
  end

  lgb_smp_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LGB_SMP_WAIT: begin
        if (push0 && two_lane_mode) state_nxt = LGB_SMP_PORT1;
      end
      LGB_SMP_PORT1: begin
        if (fifo_in_ready) state_nxt = LGB_SMP_WAIT;
      end
      default: state_nxt = LGB_SMP_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state_r <= LGB_SMP_WAIT;
    else state_r <= state_nxt;
  end

  lgb_bc_word_t w0;
  lgb_bc_word_t w1;
  lgb_bc_word_t fifo_out;
  assign w0 = '{port: 1'b0, frame_start: frame_start, pins: bc_sample[0]};
  assign w1 = '{port: 1'b1, frame_start: fs_r, pins: p1_sample_r};

  lgb_fifo #(
    .WIDTH ($bits(lgb_bc_word_t)),
    .DEPTH (LGB_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (push0 || push1),
    .in_ready  (fifo_in_ready),
    .in_data   (push1 ? w1 : w0),
    .out_valid (bc_word_valid),
    .out_ready (bc_word_ready),
    .out_data  (fifo_out)
  );
  assign bc_word = fifo_out;
endmodule

`default_nettype wire

/* File: tb/lgb_link_gpio_assertions.sv */
// Port checker of the link pin back-channel block
`timescale 1ns/1ps
`default_nettype none
module lgb_link_gpio_chk (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset_n,
  // Register access
  input wire logic                  reg_wr_en,
  input wire logic                  reg_rd_en,
  input wire logic [7:0]            reg_addr,
  input wire logic [7:0]            reg_wdata,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  reg_rd_valid,
  // Link state and pins
  input wire logic                  two_lane_mode,
  input wire logic                  power_down_input,
  input wire logic                  fwd_valid,
  input wire logic                  fwd_color_18bit,
  input wire logic                  color_18bit_mode,
  input wire logic [1:0][3:0]       link_pin_oe,
  input wire logic [4:0]            local_pin_in,
  input wire logic [4:0]            local_pin_oe,
  // Back channel
  input wire logic                  bc_word_valid,
  input wire logic                  bc_word_ready,
  input wire lgb_pkg::lgb_bc_word_t bc_word,
  input wire logic                  bc_status_enable
);
  import lgb_pkg::*;
  wire mapped = reg_addr inside {8'h1a, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h23, 8'h34, 8'h43, 8'h6e, 8'h6f};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_rd_valid_timing: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read valid not one cycle after strobe");
  a_rdata_hold: assert property (!$past(reg_rd_en) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd_en && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  a_status_high: assert property (reg_rd_en && reg_addr == 8'h6f |=> reg_rdata == {6'h00, $past(local_pin_in[4:3])})
    else $error("high status byte wrong");
  a_fast_status: assert property (reg_wr_en && reg_addr == 8'h43 |=> bc_status_enable == ($past(reg_wdata[2:0]) == 3'h0))
    else $error("status signalling not tied to mode");
  a_single_lane: assert property (!two_lane_mode && !$past(two_lane_mode) |-> link_pin_oe[1] == 4'h0)
    else $error("secondary pins driven in one-lane mode");
  a_power_down: assert property (power_down_input && $past(power_down_input) |-> link_pin_oe == 8'h00 && local_pin_oe == 5'h00)
    else $error("pins driven while powered down");
  a_bc_hold: assert property (bc_word_valid && !bc_word_ready |=> bc_word_valid && $stable(bc_word))
    else $error("back-channel word dropped while stalled");
  a_color_load: assert property (fwd_valid |=> color_18bit_mode == $past(fwd_color_18bit))
    else $error("colour mode not taken from forward channel");
endmodule
bind lgb_link_gpio lgb_link_gpio_chk i_chk (.clk, .reset_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
  .reg_rdata, .reg_rd_valid, .two_lane_mode, .power_down_input, .fwd_valid, .fwd_color_18bit, .color_18bit_mode,
  .link_pin_oe, .local_pin_in, .local_pin_oe, .bc_word_valid, .bc_word_ready, .bc_word, .bc_status_enable);
`default_nettype wire

/* File: tb/lgb_ser_model.sv */
// Behavioural model of the paired serializer across the link
`timescale 1ns/1ps
`default_nettype none
module lgb_ser_model (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Back-channel words from the device
  input  wire logic                  bc_word_valid,
  output logic                       bc_word_ready,
  input  wire lgb_pkg::lgb_bc_word_t bc_word,
  // Forward channel towards the device
  output logic                       fwd_valid,
  output logic [1:0][3:0]            fwd_value,
  output logic                       fwd_color_18bit,
  // Bench control, holds off the back channel
  input  wire logic                  stall
);
  import lgb_pkg::*;
  logic [3:0]   ser_code [4] = '{4'h3, 4'h3, 4'h3, 4'h3};
  lgb_bc_word_t got_q [$];
  initial begin
    {bc_word_ready, fwd_valid, fwd_value, fwd_color_18bit} = '0;
  end
  always @(posedge clk) begin
    bc_word_ready <= reset_n && !stall;
    if (bc_word_valid && bc_word_ready) begin
      got_q.push_back(bc_word);
    end
  end
  // Only pins coded 0x3 (input) on this end carry values
  task automatic send(input logic [1:0][3:0] v, input logic c);
    logic [1:0][3:0] m;
    foreach (ser_code[i]) begin
      m[0][i] = v[0][i] & (ser_code[i] == 4'h3);
      m[1][i] = v[1][i] & (ser_code[i] == 4'h3);
    end
    @(posedge clk);
    fwd_valid <= 1'b1;
    fwd_value <= m;
    fwd_color_18bit <= c;
    @(posedge clk);
    fwd_valid <= 1'b0;
    fwd_value <= ~m;
    fwd_color_18bit <= ~c;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_link_gpio_backchannel_control.sv */
// Self-checking bench of the link pin back-channel block
`timescale 1ns/1ps
`default_nettype none
module tb_link_gpio_backchannel_control;
  import lgb_pkg::*;
  logic            clk, reset_n, reg_wr_en, reg_rd_en, two_lane_mode, power_down_input;
  logic            strap_config_input, fwd_valid, fwd_color_18bit, color_18bit_mode, reg_rd_valid;
  logic            bc_word_valid, bc_word_ready, bc_status_enable, bc_bit_tick, stall;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata;
  logic [1:0][3:0] fwd_value, link_pin_in, link_pin_out, link_pin_oe;
  logic [4:0]      local_pin_in, local_pin_out, local_pin_oe;
  logic [3:0]      audio_data_out;
  lgb_bc_word_t    bc_word;
  int              fails = 0, n_checks = 0, cyc = 0;

  lgb_link_gpio i_dut (.clk, .reset_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
    .two_lane_mode, .power_down_input, .strap_config_input, .fwd_valid, .fwd_value, .fwd_color_18bit,
    .color_18bit_mode, .link_pin_in, .link_pin_out, .link_pin_oe, .local_pin_in, .local_pin_out, .local_pin_oe,
    .audio_data_out, .bc_word_valid, .bc_word_ready, .bc_word, .bc_status_enable, .bc_bit_tick);
  lgb_ser_model i_ser (.clk, .reset_n, .bc_word_valid, .bc_word_ready, .bc_word, .fwd_valid, .fwd_value,
    .fwd_color_18bit, .stall);

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("wrong value at %0t: run did not finish", $time);
      stop_test;
    end
  end

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    check({7'h00, reg_rd_valid}, 8'h01);
    check(reg_rdata, exp);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (bc_bit_tick !== 1'b1 && n < 20);
  endtask

  task automatic t_reset;
    rd(8'h23, 8'h00);
    @(posedge clk);
    strap_config_input <= 1'b1;
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    strap_config_input <= 1'b0;
    rd(8'h23, 8'h10);
    rd(8'h34, 8'h01);
    rd(8'h43, 8'h00);
    rd(8'h1d, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_link;
    wr(8'h1d, 8'h05);
    wr(8'h1e, 8'h39);
    wr(8'h1f, 8'h01);
    link_pin_in <= 8'h96;
    i_ser.send(8'ha5, 1'b1);
    settle;
    check({link_pin_oe[0], link_pin_out[0]}, 8'hb3);
    check({7'h00, color_18bit_mode}, 8'h01);
    rd(8'h6e, 8'h06);
    $display("link pin test done");
  endtask
  task automatic t_ports;
    @(posedge clk);
    two_lane_mode <= 1'b1;
    wr(8'h34, 8'h03);
    wr(8'h1f, 8'h09);
    settle;
    check({link_pin_oe[1][3], link_pin_out[1][3], link_pin_oe[0][3], link_pin_out[0][3], 4'h0}, 8'hf0);
    rd(8'h6e, 8'h09);
    wr(8'h34, 8'h02);
    wr(8'h1f, 8'h01);
    wr(8'h34, 8'h00);
    wr(8'h1f, 8'h03);
    wr(8'h34, 8'h01);
    rd(8'h1f, 8'h09);
    wr(8'h34, 8'h03);
    rd(8'h1f, 8'h01);
    @(posedge clk);
    two_lane_mode <= 1'b0;
    settle;
    check({4'h0, link_pin_oe[1]}, 8'h00);
    $display("port select test done");
  endtask
  task automatic t_local;
    @(posedge clk);
    local_pin_in <= 5'h1f;
    wr(8'h20, 8'h91);
    wr(8'h21, 8'h03);
    wr(8'h1a, 8'h03);
    settle;
    check({3'h0, local_pin_oe}, 8'h03);
    check({3'h0, local_pin_out}, 8'h02);
    check({4'h0, audio_data_out}, 8'h08);
    rd(8'h6e, 8'he9);
    rd(8'h6f, 8'h03);
    wr(8'h6e, 8'h00);
    rd(8'h6e, 8'he9);
    rd(8'h20, 8'h91);
    $display("local pin test done");
  endtask
  task automatic t_rate;
    logic [7:0] rv [3] = '{8'h00, 8'h40, 8'hff};
    int         per [3] = '{4, 2, 1};
    int         n;
    stall = 1'b0;
    foreach (rv[i]) begin
      wr(8'h23, rv[i]);
      gap(n);
      gap(n);
      check(n[7:0], per[i][7:0]);
    end
    rd(8'h23, 8'h50);
    $display("rate test done");
  endtask
  task automatic t_modes;
    logic [2:0] md [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
    int         spf [4] = '{1, 6, 10, 15};
    logic [3:0] msk [4] = '{4'hf, 4'hf, 4'h3, 4'h1};
    int         n;
    wr(8'h34, 8'h01);
    wr(8'h1d, 8'h03);
    wr(8'h1e, 8'h33);
    wr(8'h1f, 8'h03);
    link_pin_in <= 8'h0f;
    // Normal mode goes first, as the link must lock before fast modes
    foreach (md[i]) begin
      @(posedge clk);
      power_down_input <= 1'b1;
      stall = 1'b0;
      settle;
      for (int c = 0; c < 60 && bc_word_valid !== 1'b0; c++) begin
        @(posedge clk);
        #1;
      end
      stall = 1'b1;
      i_ser.got_q.delete();
      wr(8'h43, {5'h00, md[i]});
      settle;
      check({7'h00, bc_status_enable}, {7'h00, md[i] == 3'h0});
      @(posedge clk);
      power_down_input <= 1'b0;
      n = 0;
      for (int c = 0; c < 60 && n < 8; c++) begin
        @(posedge clk);
        #1;
        n = (bc_bit_tick === 1'b1) ? 0 : n + 1;
      end
      check(n[7:0], 8'h08);
      stall = 1'b0;
      for (int c = 0; c < 200 && i_ser.got_q.size() < 2 * spf[i]; c++) begin
        @(posedge clk);
      end
      for (int k = 0; k < 2 * spf[i]; k++) begin
        check({2'h0, i_ser.got_q[k]}, {3'h0, k % spf[i] == 0, msk[i]});
      end
    end
    $display("fast mode test done");
  endtask
  // Two-lane sampling: a port 0 word then a port 1 word of the same sample
  task automatic t_pair;
    @(posedge clk);
    power_down_input <= 1'b1;
    repeat (20) @(posedge clk);
    i_ser.got_q.delete();
    wr(8'h34, 8'h03);
    wr(8'h1d, 8'h03);
    wr(8'h1e, 8'h33);
    wr(8'h1f, 8'h03);
    wr(8'h43, 8'h00);
    @(posedge clk);
    two_lane_mode <= 1'b1;
    link_pin_in <= 8'h5a;
    power_down_input <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check({2'h0, i_ser.got_q[0]}, 8'h1a);
    check({2'h0, i_ser.got_q[1]}, 8'h35);
    $display("lane pair test done");
  endtask

  initial begin
    clk = 1'b0;
    {reset_n, reg_wr_en, reg_rd_en, two_lane_mode, power_down_input, strap_config_input, stall} = '0;
    {reg_addr, reg_wdata, link_pin_in, local_pin_in} = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_link;
    t_ports;
    t_local;
    t_rate;
    t_modes;
    t_pair;
    stop_test;
  end
endmodule
`default_nettype wire
